// *** gain_ctrl_pkg.sv ***
// Purpose: Shared constants and types for the receive gain control block
// Assumes: 40 MHz system clock, AHB-Lite register access
// Notes:   Register offsets are byte addresses of aligned words
package gain_ctrl_pkg;

    // Clock and timing
    localparam int CLK_MHZ          = 40;
    localparam int HIZ_TIME_US      = 3000;
    localparam int HIZ_CYCLES       = HIZ_TIME_US * CLK_MHZ;
    localparam int REG_PERIOD_US    = 500;
    localparam int REG_PERIOD_CYC   = REG_PERIOD_US * CLK_MHZ;
    localparam int STEP_PERIOD_US   = 100;
    localparam int STEP_PERIOD_CYC  = STEP_PERIOD_US * CLK_MHZ;
    localparam int SETTLE_TIME_US   = 20;
    localparam int SETTLE_CYC       = SETTLE_TIME_US * CLK_MHZ;

    // Gain range, startup and regulation steps
    localparam logic [6:0] GAIN_MAX      = 7'h6D;
    localparam logic [6:0] GAIN_MIN      = 7'h00;
    localparam logic [6:0] GAIN_RESET    = 7'h00;
    localparam logic [6:0] BOOST_EXTRA   = 7'h04;
    localparam logic [6:0] REDUCE_STEPS  = 7'h12;
    localparam logic [6:0] LIMIT_STEPS   = 7'h04;
    localparam logic [6:0] REG_STEPS     = 7'h01;

    // Register map
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // Control field positions
    localparam int CTRL_BYPASS_BIT  = 0;
    localparam int CTRL_BOOST_BIT   = 1;
    localparam int CTRL_REDUCE_BIT  = 2;
    localparam int CTRL_HOLD_BIT    = 3;
    localparam int CTRL_FIXED_LSB   = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Status field positions
    localparam int STAT_GAIN_LSB    = 0;
    localparam int STAT_STATE_LSB   = 8;
    localparam int STAT_SAFE_BIT    = 12;
    localparam int STAT_HIZ_BIT     = 13;
    localparam int STAT_DONE_BIT    = 14;

    // Comparator results of one channel, absolute value at or above level
    typedef struct packed {
        logic upper_limit_level;
        logic upper_regulation_level;
        logic half_upper_regulation;
        logic lower_regulation_level;
        logic lower_limit_level;
    } cmp_t;

    // Configuration as held in the control register
    typedef struct packed {
        logic [6:0] fixed_gain_value;
        logic       post_startup_hold;
        logic       startup_reduction_inhibit;
        logic       startup_boost_inhibit;
        logic       gain_bypass_select;
    } cfg_t;

    // Gain sequencer states, Gray coded along the path up to ST_REGULATE
    typedef enum logic [2:0] {
        ST_INIT     = 3'h0,
        ST_BOOST    = 3'h1,
        ST_EXTRA    = 3'h3,
        ST_REDUCE   = 3'h2,
        ST_REGULATE = 3'h6,
        ST_FROZEN   = 3'h7
    } gain_state_t;

endpackage

// *** gain_ctrl.sv ***
// Purpose: Automatic gain control for the sine and cosine receive channels
// Assumes: Comparator and supply flags arrive asynchronously from analog
// Notes:   One shared gain drives both channels; AHB-Lite, zero wait
//
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
module gain_ctrl
    import gain_ctrl_pkg::*;
#(
    parameter int HIZ_CYC  = HIZ_CYCLES,
    parameter int REG_CYC  = REG_PERIOD_CYC,
    parameter int STEP_CYC = STEP_PERIOD_CYC,
    parameter int SET_CYC  = SETTLE_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Comparator results, asynchronous
    input  wire cmp_t        sin_cmp,
    input  wire cmp_t        cos_cmp,
    // Supply monitor flags, asynchronous
    input  wire logic        overvoltage,
    input  wire logic        undervoltage,
    // Gain and output stage control
    output logic      [6:0]  channel_gain,
    output logic             outputs_hiz,
    output logic             safe_mode
);

    localparam int SYN_W = 12;

    // Elaboration checks: the period counters are only 20 bits wide
    if (HIZ_CYC < 1 || HIZ_CYC > 1048575 || REG_CYC < 1
        || REG_CYC > 1048575 || STEP_CYC < 1 || STEP_CYC > 1048575
        || SET_CYC < 1 || SET_CYC > 1048575) begin
        $error("gain_ctrl: timer parameters out of range");
    end

    // Saturating arithmetic on the gain counter
    function automatic logic [6:0] gain_up(input logic [6:0] g,
                                           input logic [6:0] n);
        logic [7:0] s;
        s = {1'b0, g} + {1'b0, n};
        gain_up = (s > {1'b0, GAIN_MAX}) ? GAIN_MAX : s[6:0];
    endfunction

    function automatic logic [6:0] gain_dn(input logic [6:0] g,
                                           input logic [6:0] n);
        gain_dn = (g > n) ? (g - n) : GAIN_MIN;
    endfunction

    function automatic logic [19:0] tick_next(input logic [19:0] c,
                                              input int          len);
        tick_next = (c >= 20'(len - 1)) ? 20'h0_0000 : c + 20'h0_0001;
    endfunction

    // Input synchronisers: three stages, accept when stages two and three agree
    logic [SYN_W-1:0] syn1_ff;
    logic [SYN_W-1:0] syn2_ff;
    logic [SYN_W-1:0] syn3_ff;
    logic [SYN_W-1:0] filt_ff;
    logic [SYN_W-1:0] nxt_filt;
    logic [SYN_W-1:0] raw_in;

    assign raw_in = {overvoltage, undervoltage, sin_cmp, cos_cmp};

    always_comb begin
        nxt_filt = filt_ff;
        for (int i = 0; i < SYN_W; i++) begin
            if (syn2_ff[i] == syn3_ff[i]) begin
                nxt_filt[i] = syn3_ff[i];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            syn1_ff <= '0;
            syn2_ff <= '0;
            syn3_ff <= '0;
            filt_ff <= '0;
        end else begin
            syn1_ff <= raw_in;
            syn2_ff <= syn1_ff;
            syn3_ff <= syn2_ff;
            filt_ff <= nxt_filt;
        end
    end

    cmp_t sin_f;
    cmp_t cos_f;
    logic supply_bad;

    assign sin_f = filt_ff[9:5];
    assign cos_f = filt_ff[4:0];
    assign supply_bad = filt_ff[11] | filt_ff[10];

    // AHB-Lite slave: read data captured in address phase, writes in data
    logic [31:0] ctrl_ff;
    logic [31:0] nxt_ctrl;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        wr_pend_ff;
    logic        nxt_wr_pend;
    logic [7:0]  wr_addr_ff;
    logic [7:0]  nxt_wr_addr;
    logic        addr_ok;
    logic [31:0] status_word;
    cfg_t        cfg;

    gain_state_t state_ff;
    gain_state_t nxt_state;
    logic [6:0]  gain_ff;
    logic [6:0]  nxt_gain;
    logic        safe_ff;
    logic        hiz_ff;

    assign cfg = cfg_t'({ctrl_ff[CTRL_FIXED_LSB +: 7],
                         ctrl_ff[CTRL_HOLD_BIT], ctrl_ff[CTRL_REDUCE_BIT],
                         ctrl_ff[CTRL_BOOST_BIT], ctrl_ff[CTRL_BYPASS_BIT]});
    assign addr_ok = hsel & hready & htrans[1];

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STAT_GAIN_LSB +: 7]  = gain_ff;
        status_word[STAT_STATE_LSB +: 3] = state_ff;
        status_word[STAT_SAFE_BIT]       = safe_ff;
        status_word[STAT_HIZ_BIT]        = hiz_ff;
        status_word[STAT_DONE_BIT]       = (state_ff == ST_REGULATE)
                                           || (state_ff == ST_FROZEN);
    end

    always_comb begin
        nxt_ctrl    = ctrl_ff;
        nxt_rdata   = rdata_ff;
        nxt_wr_pend = addr_ok & hwrite;
        nxt_wr_addr = wr_addr_ff;
        if (wr_pend_ff && wr_addr_ff == CTRL_OFFSET) begin
            nxt_ctrl = hwdata & 32'h0000_7F0F;
        end
        if (addr_ok) begin
            nxt_wr_addr = haddr[7:0];
            // Unmapped addresses read zero and ignore writes
            if (haddr[31:8] != 24'h00_0000) begin
                nxt_rdata = 32'h0000_0000;
            end else if (haddr[7:0] == CTRL_OFFSET) begin
                nxt_rdata = nxt_ctrl;
            end else if (haddr[7:0] == STATUS_OFFSET) begin
                nxt_rdata = status_word;
            end else begin
                nxt_rdata = 32'h0000_0000;
            end
            if (haddr[31:8] != 24'h00_0000) begin
                nxt_wr_addr = 8'hFF;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff    <= CTRL_RESET;
            rdata_ff   <= 32'h0000_0000;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else begin
            ctrl_ff    <= nxt_ctrl;
            rdata_ff   <= nxt_rdata;
            wr_pend_ff <= nxt_wr_pend;
            wr_addr_ff <= nxt_wr_addr;
        end
    end

    // Period timers: output hold, settle, regulation and step intervals
    logic [19:0] hiz_cnt_ff;
    logic [19:0] nxt_hiz_cnt;
    logic [19:0] set_cnt_ff;
    logic [19:0] reg_cnt_ff;
    logic [19:0] step_cnt_ff;
    logic        nxt_hiz;
    logic        nxt_safe;

    // hold outputs released after the 3 ms count
    always_comb begin
        nxt_hiz_cnt = hiz_cnt_ff;
        nxt_hiz     = hiz_ff;
        if (hiz_ff) begin
            if (hiz_cnt_ff >= 20'(HIZ_CYC - 1)) begin
                nxt_hiz = 1'b0;
            end else begin
                nxt_hiz_cnt = hiz_cnt_ff + 20'h0_0001;
            end
        end
        // either flag, one shared safe mode
        nxt_safe = supply_bad;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hiz_cnt_ff  <= 20'h0_0000;
            hiz_ff      <= 1'b1;
            safe_ff     <= 1'b0;
            set_cnt_ff  <= 20'h0_0000;
            reg_cnt_ff  <= 20'h0_0000;
            step_cnt_ff <= 20'h0_0000;
        end else begin
            hiz_cnt_ff  <= nxt_hiz_cnt;
            hiz_ff      <= nxt_hiz;
            safe_ff     <= nxt_safe;
            set_cnt_ff  <= tick_next(set_cnt_ff, SET_CYC);
            reg_cnt_ff  <= tick_next(reg_cnt_ff, REG_CYC);
            step_cnt_ff <= tick_next(step_cnt_ff, STEP_CYC);
        end
    end

    logic set_tick;
    logic reg_tick;
    logic step_tick;

    assign set_tick  = (set_cnt_ff == 20'h0_0000);
    assign reg_tick  = (reg_cnt_ff == 20'h0_0000);
    assign step_tick = (step_cnt_ff == 20'h0_0000);

    // Gate inputs from the five levels, both channels combined
    logic any_half;
    logic any_lim_h;
    logic any_reg_h;
    logic all_below_lim_l;
    logic all_below_reg_l;

    assign any_half  = sin_f.half_upper_regulation | cos_f.half_upper_regulation;
    assign any_lim_h = sin_f.upper_limit_level | cos_f.upper_limit_level;
    assign any_reg_h = sin_f.upper_regulation_level
                       | cos_f.upper_regulation_level;
    assign all_below_lim_l = ~sin_f.lower_limit_level & ~cos_f.lower_limit_level;
    assign all_below_reg_l = ~sin_f.lower_regulation_level
                             & ~cos_f.lower_regulation_level;

    // Gain sequencer: startup, regulation, freeze
    always_comb begin
        nxt_state = state_ff;
        nxt_gain  = gain_ff;
        // safe mode freezes both sequence and gain
        if (!safe_ff) begin
            case (state_ff)
                // startup begins after one settle interval
                ST_INIT: begin
                    // Wait lets software place its configuration first
                    if (set_cnt_ff == 20'(SET_CYC - 1)) begin
                        nxt_state = cfg.startup_boost_inhibit ? ST_REDUCE
                                                              : ST_BOOST;
                    end
                end
                // raise until half upper level seen
                ST_BOOST: begin
                    if (set_tick) begin
                        if (any_half || gain_ff == GAIN_MAX) begin
                            nxt_state = ST_EXTRA;
                        end else begin
                            nxt_gain = gain_up(gain_ff, REG_STEPS);
                        end
                    end
                end
                ST_EXTRA: begin
                    nxt_gain  = gain_up(gain_ff, BOOST_EXTRA);
                    nxt_state = ST_REDUCE;
                end
                ST_REDUCE: begin
                    if (!cfg.startup_reduction_inhibit) begin
                        nxt_gain = gain_dn(gain_ff, REDUCE_STEPS);
                    end
                    nxt_state = cfg.post_startup_hold ? ST_REGULATE
                                                      : ST_FROZEN;
                end
                // gate outputs pick direction and count
                ST_REGULATE: begin
                    if (step_tick && any_lim_h) begin
                        nxt_gain = gain_dn(gain_ff, LIMIT_STEPS);
                    end else if (step_tick && all_below_lim_l) begin
                        nxt_gain = gain_up(gain_ff, LIMIT_STEPS);
                    end else if (reg_tick && any_reg_h) begin
                        nxt_gain = gain_dn(gain_ff, REG_STEPS);
                    end else if (reg_tick && all_below_reg_l) begin
                        nxt_gain = gain_up(gain_ff, REG_STEPS);
                    end
                end
                ST_FROZEN: begin
                    nxt_state = ST_FROZEN;
                end
                default: begin
                    nxt_state = ST_INIT;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_INIT;
            gain_ff  <= GAIN_RESET;
        end else begin
            state_ff <= nxt_state;
            gain_ff  <= nxt_gain;
        end
    end

    // Output registers; bypass overrides the automatic gain
    logic [6:0] nxt_channel_gain;

    always_comb begin
        if (cfg.gain_bypass_select) begin
            nxt_channel_gain = cfg.fixed_gain_value;
        end else begin
            // automatic gain, shared by both channels
            nxt_channel_gain = gain_ff;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            channel_gain <= GAIN_RESET;
            outputs_hiz  <= 1'b1;
            safe_mode    <= 1'b0;
            hrdata       <= 32'h0000_0000;
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
        end else begin
            channel_gain <= nxt_channel_gain;
            outputs_hiz  <= hiz_ff;
            safe_mode    <= safe_ff;
            hrdata       <= nxt_rdata;
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
        end
    end

endmodule

// *** gain_ctrl_sva.sv ***
// Purpose: Port assertions for the receive gain control block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to every gain_ctrl instance at the foot
`timescale 1ns/100ps
module gain_ctrl_sva
    import gain_ctrl_pkg::*;
#(
    parameter int HIZ_CYC = HIZ_CYCLES
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // Bus answer
    input wire logic       hreadyout,
    input wire logic       hresp,
    // Supply flags
    input wire logic       overvoltage,
    input wire logic       undervoltage,
    // Gain and output stage
    input wire logic [6:0] channel_gain,
    input wire logic       outputs_hiz,
    input wire logic       safe_mode
);
    int nxt_age;
    int age_ff;

    // Age since release; saturates so long runs cannot wrap it
    always_comb begin
        nxt_age = age_ff;
        if (age_ff < HIZ_CYC + 8)
            nxt_age = age_ff + 1;
    end

    // Age register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            age_ff <= 0;
        else
            age_ff <= nxt_age;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // Flag held long enough to pass the input filter
    sequence supply_bad_s;
        (overvoltage || undervoltage) [*8];
    endsequence
    sequence supply_good_s;
        (!overvoltage && !undervoltage) [*8];
    endsequence

    gain_init_a: assert property (
        age_ff == 0 |-> channel_gain == GAIN_RESET)
        else $error("gain not cleared by reset");
    gain_max_a: assert property (
        channel_gain <= GAIN_MAX)
        else $error("gain above ceiling");
    hiz_hold_a: assert property (
        age_ff < HIZ_CYC |-> outputs_hiz)
        else $error("outputs driven too early");
    hiz_release_a: assert property (
        age_ff > HIZ_CYC + 4 |-> !outputs_hiz)
        else $error("outputs still high impedance");
    hiz_once_a: assert property (
        !$rose(outputs_hiz))
        else $error("high impedance entered again");
    safe_enter_a: assert property (
        supply_bad_s |-> safe_mode)
        else $error("safe mode missing on bad supply");
    safe_exit_a: assert property (
        supply_good_s |-> !safe_mode)
        else $error("safe mode kept on good supply");
    safe_freeze_a: assert property (
        safe_mode [*3] |-> $stable(channel_gain))
        else $error("gain moved in safe mode");
    ready_high_a: assert property (hreadyout)
        else $error("wait state inserted");
    okay_resp_a: assert property (!hresp)
        else $error("error response");
endmodule

bind gain_ctrl gain_ctrl_sva #(.HIZ_CYC(HIZ_CYC)) i_gain_ctrl_sva (
    .clk          (clk),
    .resetn       (resetn),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .overvoltage  (overvoltage),
    .undervoltage (undervoltage),
    .channel_gain (channel_gain),
    .outputs_hiz  (outputs_hiz),
    .safe_mode    (safe_mode)
);

// *** tb.sv ***
// Purpose: Self-checking bench for the receive gain control block
// Assumes: Shortened timing parameters, comparators driven directly
// Notes:   Bus master runs one transfer at a time
`timescale 1ns/100ps
module tb;
    import gain_ctrl_pkg::*;

    localparam int HIZ = 50;

    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    cmp_t        sin_cmp = 5'h00;
    cmp_t        cos_cmp = 5'h00;
    logic        overvoltage = 1'b0;
    logic        undervoltage = 1'b0;
    logic [6:0]  channel_gain;
    logic        outputs_hiz;
    logic        safe_mode;
    int          mismatches = 0;
    int          cmp_count = 0;
    logic [6:0]  q[$];
    logic [31:0] rd;

    // Free running 40 MHz clock
    always #12.5 clk = ~clk;

    gain_ctrl #(.HIZ_CYC(HIZ), .REG_CYC(20), .STEP_CYC(8), .SET_CYC(4))
    i_gain_ctrl (
        .clk          (clk),
        .resetn       (resetn),
        .hsel         (hsel),
        .haddr        (haddr),
        .htrans       (htrans),
        .hwrite       (hwrite),
        .hsize        (hsize),
        .hwdata       (hwdata),
        .hready       (hreadyout),
        .hrdata       (hrdata),
        .hreadyout    (hreadyout),
        .hresp        (hresp),
        .sin_cmp      (sin_cmp),
        .cos_cmp      (cos_cmp),
        .overvoltage  (overvoltage),
        .undervoltage (undervoltage),
        .channel_gain (channel_gain),
        .outputs_hiz  (outputs_hiz),
        .safe_mode    (safe_mode)
    );

    // Compare and count; four-state so an unknown never matches
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Reset held 8 cycles with comparators cleared
    task automatic do_reset();
        resetn  <= 1'b0;
        sin_cmp <= 5'h00;
        cos_cmp <= 5'h00;
        cyc(8);
        resetn  <= 1'b1;
    endtask

    // One single word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        rd = hrdata;
    endtask

    // Log each new gain; lift sine above half level once trig is hit
    task automatic watch(input int n, input logic [6:0] trig);
        q = {};
        q.push_back(channel_gain);
        repeat (n) begin
            @(posedge clk);
            if (channel_gain !== q[$])
                q.push_back(channel_gain);
            if (channel_gain === trig)
                sin_cmp <= 5'h07;
        end
    endtask

    // Wait up to 60 cycles for a change and compare its size
    task automatic step_is(input string what, input int d);
        logic [6:0] g0;
        g0 = channel_gain;
        repeat (60) begin
            @(posedge clk);
            if (channel_gain !== g0)
                break;
        end
        check(what, channel_gain, 7'(g0 + 7'(d)));
    endtask

    task automatic t_startup();
        do_reset();
        @(posedge clk);
        check("reset gain", channel_gain, GAIN_RESET);
        check("hiz early", outputs_hiz, 1'b1);
        bus(1'b0, 32'h0, 32'h0);
        check("ctrl reset", rd, CTRL_RESET);
        watch(600, 7'h1E);
        check("boost start", q[1], 7'h01);
        check("boost extra", q[$-1] - q[$-2], 7'h04);
        check("reduction", q[$-1] - q[$], 7'h12);
        check("hiz late", outputs_hiz, 1'b0);
        sin_cmp <= 5'h1F;
        watch(200, 7'h7F);
        check("frozen", q.size(), 1);
    endtask

    task automatic t_saturate();
        do_reset();
        watch(800, 7'h7F);
        check("gain peak", q[$-1], GAIN_MAX);
        check("after peak", q[$], 7'h5B);
    endtask

    task automatic t_regulate();
        cmp_t s[5] = '{5'h1F, 5'h03, 5'h00, 5'h01, 5'h01};
        cmp_t c[5] = '{5'h03, 5'h0F, 5'h00, 5'h01, 5'h03};
        int   d[5] = '{-4, -1, 4, 1, 0};
        do_reset();
        bus(1'b1, 32'h0, 32'h0000_000C);
        watch(600, 7'h14);
        check("no reduction", q[$] - q[$-1], 7'h04);
        // Each case starts from the settled in-window state
        for (int i = 0; i < 5; i++) begin
            sin_cmp <= 5'h03;
            cos_cmp <= 5'h03;
            cyc(6);
            step_is("window", 0);
            sin_cmp <= s[i];
            cos_cmp <= c[i];
            step_is("reg step", d[i]);
        end
        sin_cmp <= 5'h1F;
        cyc(300);
        check("gain floor", channel_gain, GAIN_MIN);
        sin_cmp <= 5'h01;
        cos_cmp <= 5'h01;
        cyc(40);
        // Undervoltage first, then overvoltage
        for (int i = 0; i < 2; i++) begin
            {overvoltage, undervoltage} <= (i == 0) ? 2'h1 : 2'h2;
            cyc(10);
            check("safe on", safe_mode, 1'b1);
            rd = channel_gain;
            cyc(60);
            check("safe hold", channel_gain, rd);
            {overvoltage, undervoltage} <= 2'h0;
            step_is("resume", 1);
            check("safe off", safe_mode, 1'b0);
        end
        sin_cmp <= 5'h00;
        cos_cmp <= 5'h00;
        cyc(400);
        check("gain ceiling", channel_gain, GAIN_MAX);
    endtask

    task automatic t_bypass();
        bus(1'b1, 32'h0, 32'hFFFF_AD0F);
        bus(1'b0, 32'h0, 32'h0);
        check("ctrl read", rd, 32'h0000_2D0F);
        cyc(4);
        check("fixed gain", channel_gain, 7'h2D);
        sin_cmp <= 5'h1F;
        cyc(300);
        check("fixed hold", channel_gain, 7'h2D);
        bus(1'b1, 32'h8, 32'hFFFF_FFFF);
        bus(1'b0, 32'h8, 32'h0);
        check("unmapped", rd, 32'h0);
        bus(1'b0, 32'h4, 32'h0);
        check("status", rd & 32'h0000_607F, 32'h0000_4000);
        bus(1'b1, 32'h0, 32'h0000_0008);
        cyc(4);
        check("auto again", channel_gain, GAIN_MIN);
    endtask

    // Boost inhibited before startup; in-window levels keep gain still
    task automatic t_no_boost();
        do_reset();
        sin_cmp <= 5'h03;
        cos_cmp <= 5'h03;
        bus(1'b1, 32'h0, 32'h0000_000A);
        watch(100, 7'h7F);
        check("boost skipped", q.size(), 1);
        check("no boost gain", q[0], GAIN_RESET);
        bus(1'b0, 32'h4, 32'h0);
        check("no boost state", rd & 32'h0000_4700, 32'h0000_4600);
    endtask

    // Verdict and end of run
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        t_startup();
        $display("test startup done");
        t_saturate();
        $display("test saturate done");
        t_regulate();
        $display("test regulate done");
        t_bypass();
        $display("test bypass done");
        t_no_boost();
        $display("test no boost done");
        conclude();
    end

    // Watchdog, well past the roughly 4000 cycles expected
    initial begin
        cyc(20000);
        mismatches++;
        conclude();
    end
endmodule
